// ==== verilog/ebdtc_pkg.sv ====
// Constants shared by the external bus timing controller files
package ebdtc_pkg;
    // ********************************************************
    // Register byte addresses
    // ********************************************************
    localparam logic [7:0] A_ACS  = 8'h00;
    localparam logic [7:0] A_WAIT = 8'h04;
    localparam logic [7:0] A_BIC  = 8'h08;
    localparam logic [7:0] A_RST  = 8'h0C;
    localparam logic [7:0] A_DIC  = 8'h10;
    localparam logic [7:0] A_DAT  = 8'h14;
    localparam logic [7:0] A_REF  = 8'h18;
    localparam logic [7:0] A_CNT  = 8'h1C;
    localparam logic [7:0] A_COR  = 8'h20;
    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0]  ACS_RST  = 8'hFF;
    localparam logic [2:0]  WAIT_RST = 3'h7;
    localparam logic [15:0] ZERO16   = 16'h0000;
    localparam logic [7:0]  CNT_RST  = 8'h00;
    localparam logic [7:0]  COR_RST  = 8'hFF;
    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int ACS_AST  = 0;
    localparam int ACS_ABW  = 4;
    localparam int BIC_WRITE_BUFFER_ENABLE = 8;
    localparam int BIC_IDLE = 2;
    localparam int BIC_IDLC = 0;
    localparam int RST_RDN  = 4;
    localparam int DIC_ROW_STROBE_TIMING_SEL = 14;
    localparam int DIC_COLUMN_CYCLE_LENGTH_SEL = 12;
    localparam int DIC_AREA2_DRAM_SELECT = 8;
    localparam int DIC_BRST = 7;
    localparam int DIC_ROW_STROBE_DOWN_MODE = 6;
    localparam int DIC_DDS  = 5;
    localparam int DIC_MXC  = 0;
    localparam int DAT_TPC  = 4;
    localparam int DAT_RCD  = 0;
    localparam int REF_FLAG = 15;
    localparam int REF_EN   = 7;
    localparam int ROW_BASE = 8;
    localparam logic [1:0] DRAM_AREA = 2'd2;
    // ********************************************************
    // Sequencer states
    // ********************************************************
    typedef enum logic [10:0] {
        S_IDLE = 11'h001, S_GAP = 11'h002, S_T1  = 11'h004,
        S_TW   = 11'h008, S_TL  = 11'h010, S_PRE = 11'h020,
        S_ROW  = 11'h040, S_RCD = 11'h080, S_COL = 11'h100,
        S_RFC  = 11'h200, S_RFR = 11'h400
    } ebdtc_state_e;
endpackage

// ==== verilog/ebdtc_ref_if.sv ====
// Link between the controller and its refresh timer
interface ebdtc_ref_if;
    logic       tick;
    logic       cnt_we;
    logic       cor_we;
    logic [7:0] wdata;
    logic [7:0] cnt;
    logic [7:0] cor;
    logic       match;
    modport ctrl (output tick, cnt_we, cor_we, wdata, input cnt, cor, match);
    modport tmr  (input tick, cnt_we, cor_we, wdata, output cnt, cor, match);
endinterface

// ==== verilog/ebdtc_refresh_timer.sv ====
// Refresh counter and time constant with compare match
module ebdtc_refresh_timer
    import ebdtc_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic reset_i,
    ebdtc_ref_if.tmr  rif
);
    logic [7:0] cnt_r;
    logic [7:0] cor_r;

    assign rif.match = (cnt_r == cor_r);
    assign rif.cnt   = cnt_r;
    assign rif.cor   = cor_r;

    // ********************************************************
    // Counter
    // ********************************************************
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= CNT_RST;
        end else if (rif.cnt_we) begin
            cnt_r <= rif.wdata;
        end else if (rif.match) begin
            cnt_r <= CNT_RST;
        end else if (rif.tick) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cor_r <= COR_RST;
        end else if (rif.cor_we) begin
            cor_r <= rif.wdata;
        end
    end

    property p_match_clear;
        @(posedge clock_i) disable iff (reset_i)
        rif.match && !rif.cnt_we |=> cnt_r == CNT_RST;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("counter not cleared");
endmodule

// ==== verilog/ebdtc_ctrl.sv ====
// External bus and DRAM timing controller, top level
// ********************************************************
// ********************************************************
module ebdtc_ctrl
    import ebdtc_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        refresh_tick_i,
    input  wire logic        req_i,
    input  wire logic        req_write_i,
    input  wire logic [1:0]  req_area_i,
    input  wire logic [23:0] req_addr_i,
    input  wire logic        req_dma_single_i,
    output logic             done_o,
    output logic      [3:0]  cs_n_o,
    output logic             rd_n_o,
    output logic             rd_early_o,
    output logic             wr_n_o,
    output logic             ras_n_o,
    output logic             ras_rise_o,
    output logic             cas_n_o,
    output logic             dma_transfer_ack_o,
    output logic             wbuf_use_o,
    output logic      [23:0] mem_addr_o,
    output logic             compare_match_flag_o
);
    // ********************************************************
    // Registers
    // ********************************************************
    logic [7:0]   acs_r;
    logic [2:0]   wait_r;
    logic [15:0]  bic_r;
    logic [7:0]   rst_r;
    logic [15:0]  dic_r;
    logic [7:0]   dat_r;
    logic [14:0]  ref_r;
    logic         flag_r;
    logic         flag_seen_r;
    logic [15:0]  rdata_r;
    ebdtc_ref_if  rif ();

    ebdtc_refresh_timer u_timer (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .rif     (rif)
    );

    function automatic logic [23:0] row_mask(input logic [2:0] mxc, input logic wide);
        logic [4:0] lo;
        lo = 5'(ROW_BASE) + {2'b00, mxc} + {4'h0, wide};
        row_mask = 24'hFF_FFFF << lo;
    endfunction

    logic wr_hit;
    logic rd_hit;
    assign wr_hit = reg_wr_i;
    assign rd_hit = reg_rd_i;

    assign rif.tick   = refresh_tick_i;
    assign rif.wdata  = reg_wdata_i[7:0];
    assign rif.cnt_we = wr_hit && reg_addr_i == A_CNT;
    assign rif.cor_we = wr_hit && reg_addr_i == A_COR;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            acs_r  <= ACS_RST;
            wait_r <= WAIT_RST;
            bic_r  <= ZERO16;
            rst_r  <= ZERO16[7:0];
            dic_r  <= ZERO16;
            dat_r  <= ZERO16[7:0];
            ref_r  <= ZERO16[14:0];
        end else if (wr_hit) begin
            case (reg_addr_i)
                A_ACS:   acs_r  <= reg_wdata_i[7:0];
                A_WAIT:  wait_r <= reg_wdata_i[2:0];
                A_BIC:   bic_r  <= reg_wdata_i;
                A_RST:   rst_r  <= reg_wdata_i[7:0];
                A_DIC:   dic_r  <= reg_wdata_i;
                A_DAT:   dat_r  <= reg_wdata_i[7:0];
                A_REF:   ref_r  <= reg_wdata_i[14:0];
                default: acs_r  <= acs_r;
            endcase
        end
    end

    logic rfsh_on;
    logic cbr_done;
    assign rfsh_on = ref_r[REF_EN];

    // Flag: a match in the clearing cycle wins
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            flag_r      <= 1'b0;
            flag_seen_r <= 1'b0;
        end else begin
            if (rd_hit && reg_addr_i == A_REF) begin
                flag_seen_r <= flag_r;
            end
            if (rif.match) begin
                flag_r <= 1'b1;
            end else if (rfsh_on && cbr_done) begin
                flag_r <= 1'b0;
            end else if (!rfsh_on && wr_hit && reg_addr_i == A_REF
                         && !reg_wdata_i[REF_FLAG] && flag_seen_r) begin
                flag_r      <= 1'b0;
                flag_seen_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_r <= ZERO16;
        end else if (rd_hit) begin
            case (reg_addr_i)
                A_ACS:   rdata_r <= {8'h00, acs_r};
                A_WAIT:  rdata_r <= {13'h0000, wait_r};
                A_BIC:   rdata_r <= bic_r;
                A_RST:   rdata_r <= {8'h00, rst_r};
                A_DIC:   rdata_r <= dic_r;
                A_DAT:   rdata_r <= {8'h00, dat_r};
                A_REF:   rdata_r <= {flag_r, ref_r};
                A_CNT:   rdata_r <= {8'h00, rif.cnt};
                A_COR:   rdata_r <= {8'h00, rif.cor};
                default: rdata_r <= ZERO16;
            endcase
        end else begin
            rdata_r <= ZERO16;
        end
    end
    assign reg_rdata_o          = rdata_r;
    assign compare_match_flag_o = flag_r;

    // ********************************************************
    // Access sequencer
    // ********************************************************
    ebdtc_state_e st_r;
    ebdtc_state_e st_nxt;
    logic [2:0]   cnt_r;
    logic [2:0]   cnt_nxt;
    logic         ref_pend_r;
    logic         pre_ref_r;
    logic         ras_open_r;
    logic         ras_open_nxt;
    logic [23:0]  row_r;
    logic [23:0]  cur_addr_r;
    logic [1:0]   cur_area_r;
    logic         cur_wr_r;
    logic         cur_single_r;
    logic         buf_r;
    logic         last_ok_r;
    logic [1:0]   last_area_r;
    logic         last_wr_r;
    logic         last_single_r;

    logic         be;
    logic         row_strobe_down_mode;
    logic [1:0]   idle_code;
    logic         is_dram;
    logic         hit;
    logic         idle_need;
    logic         need_gap;
    logic         start;
    logic         start_buf;
    logic         end_acc;
    logic [2:0]   col_len;

    assign be        = dic_r[DIC_BRST];
    assign row_strobe_down_mode      = dic_r[DIC_ROW_STROBE_DOWN_MODE];
    assign idle_code = bic_r[BIC_IDLE+:2];
    assign col_len   = dic_r[DIC_COLUMN_CYCLE_LENGTH_SEL] ? 3'd2 : 3'd1;
    assign is_dram   = req_area_i == DRAM_AREA && dic_r[DIC_AREA2_DRAM_SELECT];
    // burst only on open same row
    assign hit = ras_open_r && is_dram && be && (!req_dma_single_i || dic_r[DIC_DDS])
                 && ((req_addr_i ^ row_r)
                     & row_mask(dic_r[DIC_MXC+:3], !acs_r[ACS_ABW + 32'(req_area_i)])) == 24'h0;
    assign idle_need = last_ok_r && (
        (idle_code != 2'b00 && (last_single_r
            || (!req_write_i && !last_wr_r && req_area_i != last_area_r)))
        || (idle_code[1] && req_write_i && !last_wr_r)
        || (idle_code == 2'b11 && !req_write_i && last_wr_r));
    // single idle state to end held row
    assign need_gap  = idle_need || (ras_open_r && row_strobe_down_mode && is_dram && !hit);
    assign start     = st_r == S_IDLE && !ref_pend_r && req_i && !need_gap;
    // buffered writes release the master at once
    assign start_buf = start && bic_r[BIC_WRITE_BUFFER_ENABLE] && (req_write_i || req_dma_single_i);
    assign end_acc   = st_r == S_TL || (st_r == S_COL && cnt_r == 3'd0);
    assign cbr_done  = st_r == S_RFR;
    assign done_o    = start_buf || (end_acc && !buf_r);

    // Take-cycle pins must follow the new request, not the previous access
    logic        eff_wr;
    logic        eff_single;
    logic        eff_buf;
    logic [1:0]  eff_area;
    logic [23:0] eff_addr;
    assign eff_wr     = start ? req_write_i : cur_wr_r;
    assign eff_single = start ? req_dma_single_i : cur_single_r;
    assign eff_buf    = start ? start_buf : buf_r;
    assign eff_area   = start ? req_area_i : cur_area_r;
    assign eff_addr   = start ? req_addr_i : cur_addr_r;

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        if (cnt_r != 3'd0) begin
            cnt_nxt = cnt_r - 3'd1;
        end
        case (st_r)
            S_IDLE: begin
                if (ref_pend_r) begin
                    st_nxt  = S_PRE;
                    cnt_nxt = 3'(dat_r[DAT_TPC+:2]);
                end else if (req_i && need_gap) begin
                    st_nxt  = S_GAP;
                    cnt_nxt = idle_need ? 3'(bic_r[BIC_IDLC+:2]) : 3'd0;
                end else if (req_i && hit) begin
                    st_nxt  = S_COL;
                    cnt_nxt = col_len;
                end else if (req_i && is_dram) begin
                    st_nxt  = S_PRE;
                    cnt_nxt = 3'(dat_r[DAT_TPC+:2]);
                end else if (req_i) begin
                    st_nxt  = S_T1;
                end
            end
            S_GAP:   st_nxt = (cnt_r == 3'd0) ? S_IDLE : S_GAP;
            S_T1: begin
                if (acs_r[ACS_AST + 32'(cur_area_r)]) begin
                    st_nxt  = S_TW;
                    cnt_nxt = (cur_area_r == 2'd0) ? wait_r : 3'd0;
                end else begin
                    st_nxt  = S_TL;
                end
            end
            S_TW:    st_nxt = (cnt_r == 3'd0) ? S_TL : S_TW;
            S_TL:    st_nxt = S_IDLE;
            S_PRE:   st_nxt = (cnt_r != 3'd0) ? S_PRE : (pre_ref_r ? S_RFC : S_ROW);
            S_ROW: begin
                if (dat_r[DAT_RCD+:2] != 2'b00) begin
                    st_nxt  = S_RCD;
                    cnt_nxt = 3'(dat_r[DAT_RCD+:2]) - 3'd1;
                end else begin
                    st_nxt  = S_COL;
                    cnt_nxt = col_len;
                end
            end
            S_RCD: begin
                if (cnt_r == 3'd0) begin
                    st_nxt  = S_COL;
                    cnt_nxt = col_len;
                end
            end
            S_COL:   st_nxt = (cnt_r == 3'd0) ? S_IDLE : S_COL;
            S_RFC:   st_nxt = S_RFR;
            S_RFR:   st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    // held row closes unless down mode or a same-row burst keeps it
    always_comb begin
        ras_open_nxt = ras_open_r;
        if (st_r == S_COL && cnt_r == 3'd0) begin
            ras_open_nxt = be;
        end else if (!be || st_nxt == S_PRE || st_r == S_GAP) begin
            ras_open_nxt = 1'b0;
        end else if (!row_strobe_down_mode && !(st_nxt == S_COL || st_r == S_COL)) begin
            ras_open_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            st_r       <= S_IDLE;
            cnt_r      <= 3'd0;
            ras_open_r <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            ras_open_r <= ras_open_nxt;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ref_pend_r <= 1'b0;
            pre_ref_r  <= 1'b0;
        end else begin
            if (rif.match && rfsh_on) begin
                ref_pend_r <= 1'b1;
            end else if (st_r == S_IDLE && ref_pend_r) begin
                ref_pend_r <= 1'b0;
            end
            if (st_r == S_IDLE) begin
                pre_ref_r <= ref_pend_r;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cur_addr_r    <= 24'h00_0000;
            row_r         <= 24'h00_0000;
            cur_area_r    <= 2'd0;
            cur_wr_r      <= 1'b0;
            cur_single_r  <= 1'b0;
            buf_r         <= 1'b0;
            last_ok_r     <= 1'b0;
            last_area_r   <= 2'd0;
            last_wr_r     <= 1'b0;
            last_single_r <= 1'b0;
        end else if (start) begin
            cur_addr_r    <= req_addr_i;
            cur_area_r    <= req_area_i;
            cur_wr_r      <= req_write_i;
            cur_single_r  <= req_dma_single_i;
            buf_r         <= start_buf;
            last_ok_r     <= 1'b1;
            last_area_r   <= req_area_i;
            last_wr_r     <= req_write_i;
            last_single_r <= req_dma_single_i;
            if (is_dram) begin
                row_r <= req_addr_i;
            end
        end else if (st_r == S_GAP && cnt_r == 3'd0) begin
            last_ok_r <= 1'b0;
        end
    end

    // ********************************************************
    // Pin outputs, registered from next state
    // ********************************************************
    logic norm_n;
    logic dram_n;
    logic ack_n;
    assign norm_n = st_nxt == S_T1 || st_nxt == S_TW || st_nxt == S_TL;
    assign dram_n = st_nxt == S_ROW || st_nxt == S_RCD || st_nxt == S_COL;
    // option delays acknowledge to the column phase
    assign ack_n  = dic_r[DIC_DDS] ? st_nxt == S_COL : (norm_n || dram_n);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cs_n_o             <= 4'hF;
            rd_n_o             <= 1'b1;
            rd_early_o         <= 1'b0;
            wr_n_o             <= 1'b1;
            ras_n_o            <= 1'b1;
            ras_rise_o         <= 1'b0;
            cas_n_o            <= 1'b1;
            dma_transfer_ack_o <= 1'b0;
            wbuf_use_o         <= 1'b0;
            mem_addr_o         <= 24'h00_0000;
        end else begin
            cs_n_o     <= norm_n ? ~(4'h1 << eff_area) : 4'hF;
            rd_n_o     <= !((norm_n || st_nxt == S_COL) && !eff_wr);
            // pad logic negates half a state early
            rd_early_o <= norm_n && !eff_wr && rst_r[RST_RDN + 32'(eff_area)];
            wr_n_o     <= !(eff_wr && (st_nxt == S_TW || st_nxt == S_TL
                                       || st_nxt == S_COL));
            ras_n_o    <= !(dram_n || st_nxt == S_RFR || ras_open_nxt);
            ras_rise_o <= dic_r[DIC_ROW_STROBE_TIMING_SEL];
            cas_n_o    <= !(st_nxt == S_COL || st_nxt == S_RFC || st_nxt == S_RFR);
            dma_transfer_ack_o <= eff_single && ack_n;
            wbuf_use_o <= eff_buf && (norm_n || dram_n);
            // row shift by 8 plus code
            if (st_nxt == S_ROW || st_nxt == S_RCD) begin
                mem_addr_o <= eff_addr >> (ROW_BASE + 32'(dic_r[DIC_MXC+:2]));
            end else begin
                mem_addr_o <= eff_addr;
            end
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    property p_area0_wait;
        @(posedge clock_i) disable iff (reset_i)
        st_r == S_T1 && cur_area_r == 2'd0 && acs_r[ACS_AST]
        |=> st_r == S_TW && cnt_r == $past(wait_r);
    endproperty
    a_area0_wait: assert property (p_area0_wait) else $error("area 0 wait count");
    property p_buf_done;
        @(posedge clock_i) disable iff (reset_i)
        start && bic_r[BIC_WRITE_BUFFER_ENABLE] && req_write_i |-> done_o ##1 !done_o [*2];
    endproperty
    a_buf_done: assert property (p_buf_done) else $error("buffered write release");
    property p_idle_len;
        @(posedge clock_i) disable iff (reset_i)
        st_r == S_IDLE && req_i && !ref_pend_r && idle_need
        |=> st_r == S_GAP && cnt_r == $past(3'(bic_r[BIC_IDLC+:2]));
    endproperty
    a_idle_len: assert property (p_idle_len) else $error("idle state count");
    property p_pre_len;
        @(posedge clock_i) disable iff (reset_i)
        st_r != S_PRE ##1 st_r == S_PRE |-> cnt_r == 3'(dat_r[DAT_TPC+:2]);
    endproperty
    a_pre_len: assert property (p_pre_len) else $error("precharge length");
    property p_col_len;
        @(posedge clock_i) disable iff (reset_i)
        st_r == S_ROW && dat_r[DAT_RCD+:2] == 2'b00 |=> st_r == S_COL && cnt_r == $past(col_len);
    endproperty
    a_col_len: assert property (p_col_len) else $error("column length");
    property p_rcd;
        @(posedge clock_i) disable iff (reset_i)
        st_r == S_ROW && dat_r[DAT_RCD+:2] == 2'b10 |=> st_r == S_RCD ##2 st_r == S_COL;
    endproperty
    a_rcd: assert property (p_rcd) else $error("row to column wait");
    property p_up_close;
        @(posedge clock_i) disable iff (reset_i)
        ras_open_r && !row_strobe_down_mode && st_r == S_IDLE && st_nxt != S_COL |=> !ras_open_r && ras_n_o;
    endproperty
    a_up_close: assert property (p_up_close) else $error("row strobe not raised");
    property p_flag_set;
        @(posedge clock_i) disable iff (reset_i)
        rif.match |=> flag_r;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("match flag not set");
endmodule

// ==== tb/ebdtc_mem_model.sv ====
// Far-side memory monitor that logs strobe events
module ebdtc_mem_model (
    input  wire logic clock_i,
    input  wire logic rd_n_i,
    input  wire logic rd_early_i,
    input  wire logic ras_n_i,
    input  wire logic cas_n_i,
    output logic      early_o,
    output logic      cbr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clock_i) begin
        if (!rd_n_i) begin
            early_o <= rd_early_i;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!cas_n_i && ras_n_i) begin
            cbr_o <= 1'b1;
        end else if (!ras_n_i && cas_n_i) begin
            cbr_o <= 1'b0;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Bench for the external bus timing controller
module testbench
    import ebdtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i, reset_i, wr, rd, tick, req, rw, dma;
    logic        done, rdn, rde, rasn, casn, rise, wbuf, early, cbr, compare_match_flag;
    logic [3:0]  cs;
    logic [7:0]  addr;
    logic [15:0] wd, rdata;
    logic [1:0]  area;
    logic [23:0] ra;
    int          fail_count, total_checks, cyc, lat;
    ebdtc_ctrl ebdtc_ctrl_inst (.clock_i, .reset_i, .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .refresh_tick_i(tick),
        .req_i(req), .req_write_i(rw), .req_area_i(area), .req_addr_i(ra),
        .req_dma_single_i(dma), .done_o(done), .cs_n_o(cs), .rd_n_o(rdn), .rd_early_o(rde),
        .wr_n_o(), .ras_n_o(rasn), .ras_rise_o(rise), .cas_n_o(casn),
        .dma_transfer_ack_o(), .wbuf_use_o(wbuf), .mem_addr_o(), .compare_match_flag_o(compare_match_flag));
    ebdtc_mem_model ebdtc_mem_model_inst (.clock_i, .rd_n_i(rdn), .rd_early_i(rde),
        .ras_n_i(rasn), .cas_n_i(casn), .early_o(early), .cbr_o(cbr));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr <= 1;
        addr <= a;
        wd <= d;
        @(posedge clock_i);
        wr <= 0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock_i);
        rd <= 1;
        addr <= a;
        @(posedge clock_i);
        rd <= 0;
        @(negedge clock_i);
        chk(rdata, e);
    endtask
    // Request held high across back-to-back accesses
    task automatic acc(input logic w, input logic [1:0] ar, input logic [23:0] ad,
                       input logic d);
        @(posedge clock_i);
        req <= 1;
        rw <= w;
        area <= ar;
        ra <= ad;
        dma <= d;
        lat = 0;
        @(negedge clock_i);
        while (done !== 1'b1 && lat < 60) begin
            @(negedge clock_i);
            lat++;
        end
    endtask
    task automatic idle();
        @(posedge clock_i);
        req <= 0;
    endtask
    task automatic ticks();
        @(posedge clock_i);
        tick <= 1;
        repeat (3) @(posedge clock_i);
        tick <= 0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        clock_i = 0;
        forever #5 clock_i = ~clock_i;
    end
    // Hang guard: the run needs well under this many cycles
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        {reset_i, wr, rd, tick, req, rw, dma} = 7'h01 << 6;
        {addr, wd, area, ra} = '0;
        repeat (20) @(posedge clock_i);
        reset_i <= 0;
        rreg(A_ACS, 16'h00FF);
        rreg(A_WAIT, 16'h0007);
        rreg(A_COR, 16'h00FF);
        rreg(8'h24, 16'h0000);
        for (int w = 0; w < 8; w += 7) begin
            wreg(A_WAIT, 16'(w));
            acc(0, 0, 24'h00_0100, 0);
            chk(16'(cs), 16'h000E);
            idle();
            chk(16'(lat), 16'(3 + w));
        end
        $display("wait test done");
        wreg(A_ACS, 16'h00F0);
        // Idle code and length move together so each gap case differs
        for (int c = 0; c < 4; c++) begin
            wreg(A_BIC, 16'(c * 5));
            rreg(A_BIC, 16'(c * 5));
            acc(0, 1, 24'h20_0000, 0);
            acc(0, 3, 24'hE0_0000, 0);
            chk(16'(lat), 16'(c >= 1 ? 4 + c : 2));
            acc(1, 3, 24'hE0_0002, 0);
            chk(16'(lat), 16'(c >= 2 ? 4 + c : 2));
            acc(0, 3, 24'hE0_0004, 0);
            chk(16'(lat), 16'(c == 3 ? 4 + c : 2));
            acc(0, 3, 24'hE0_0006, 1);
            acc(0, 3, 24'hE0_0008, 0);
            chk(16'(lat), 16'(c >= 1 ? 4 + c : 2));
            idle();
        end
        wreg(A_BIC, 16'h0000);
        $display("idle test done");
        wreg(A_RST, 16'h0020);
        acc(0, 1, 24'h20_0010, 0);
        chk(16'(early), 16'h0001);
        acc(0, 0, 24'h00_0010, 0);
        acc(0, 0, 24'h00_0012, 0);
        idle();
        repeat (2) @(negedge clock_i);
        chk(16'(early), 16'h0000);
        $display("strobe test done");
        wreg(A_DAT, 16'h0032);
        for (int k = 0; k < 4; k++) begin
            wreg(A_DIC, 16'h5100 | 16'(k > 0) << 7 | 16'(k >= 2) << 5);
            acc(0, 2, 24'h40_0000, k[0]);
            chk(16'(lat), 16'h000A);
            acc(0, 2, 24'h40_0002, k[0]);
            chk(16'(lat), 16'(k >= 2 ? 3 : 10));
            idle();
            chk(16'(rise), 16'h0001);
        end
        // Down mode holds the row across a normal access until cleared
        wreg(A_DIC, 16'h51C0);
        acc(0, 2, 24'h40_0100, 0);
        chk(16'(lat), 16'h000A);
        acc(0, 1, 24'h20_0030, 0);
        chk(16'(rasn), 16'h0000);
        idle();
        wreg(A_DIC, 16'h5180);
        repeat (2) @(negedge clock_i);
        chk(16'(rasn), 16'h0001);
        $display("dram test done");
        wreg(A_BIC, 16'h0100);
        acc(1, 1, 24'h20_0020, 0);
        chk(16'(lat), 16'h0000);
        idle();
        @(negedge clock_i);
        chk(16'(wbuf), 16'h0001);
        $display("buffer test done");
        wreg(A_COR, 16'h0003);
        ticks();
        rreg(A_REF, 16'h8000);
        chk(16'(compare_match_flag), 16'h0001);
        rreg(A_CNT, 16'h0000);
        wreg(A_REF, 16'h0000);
        rreg(A_REF, 16'h0000);
        wreg(A_REF, 16'h0080);
        ticks();
        repeat (30) @(posedge clock_i);
        rreg(A_REF, 16'h0080);
        chk(16'(compare_match_flag), 16'h0000);
        chk(16'(cbr), 16'h0001);
        $display("refresh test done");
        conclude();
    end
endmodule
